// ==== inc/mvd_defines.vh ====
// opcodes, psw bit positions, reset values and cycle counts for the move decoder
// assumes bytes arrive from the fetch unit one per valid strobe
`ifndef MVD_DEFINES_VH
`define MVD_DEFINES_VH
`define MVD_OP_MOV_A_IMM    8'h74
`define MVD_OP_MOV_A_IND    7'h73
`define MVD_OP_MOV_C_BIT    8'ha2
`define MVD_OP_MOV_DP_IMM   8'h90
`define MVD_PSW_CY          7
`define MVD_PSW_RS1         4
`define MVD_PSW_RS0         3
`define MVD_PSW_P           0
`define MVD_RST_ACC         8'h00
`define MVD_RST_PSW         8'h00
`define MVD_RST_DP          16'h0000
`define MVD_CYC_ONE         2'h1
`define MVD_CYC_TWO         2'h2
`endif

// ==== design/mvd_parity.v ====
// even-parity generator for the psw parity flag
// purely combinational
`timescale 1ns/1ps
module mvd_parity #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] data_i,
  output wire             parity_o
);
  // set when the count of ones is odd
  assign parity_o = ^data_i;
endmodule

// ==== design/mvd_move_decode.v ====
// decode and execute of accumulator, carry and data pointer moves
// assumes fetch presents one byte per byte_valid_i pulse; memory read is combinational on mem_addr_o
`timescale 1ns/1ps
`include "mvd_defines.vh"
module mvd_move_decode #(
  parameter DATA_W = 8
) (
  input  wire              ref_clk_i,
  input  wire              rst_b_i,
  input  wire              byte_valid_i,
  input  wire [DATA_W-1:0] byte_i,
  input  wire [DATA_W-1:0] work_reg0_i,
  input  wire [DATA_W-1:0] work_reg1_i,
  input  wire [DATA_W-1:0] mem_data_i,
  input  wire              bit_value_i,
  output reg  [DATA_W-1:0] mem_addr_o,
  output reg               mem_rd_o,
  output reg  [DATA_W-1:0] bit_addr_o,
  output reg               bit_rd_o,
  output reg  [DATA_W-1:0] accumulator_o,
  output reg  [DATA_W-1:0] program_status_word_o,
  output reg  [2*DATA_W-1:0] data_pointer_o,
  output reg               busy_o,
  output reg               done_o,
  output reg  [1:0]        cycles_o
);
  localparam ST_OPC    = 3'h0;
  localparam ST_IMM    = 3'h1;
  localparam ST_IND    = 3'h2;
  localparam ST_BITA   = 3'h3;
  localparam ST_BITV   = 3'h4;
  localparam ST_DPH    = 3'h5;
  localparam ST_DPL    = 3'h6;

  // opcode classes seen by the idle state
  localparam CL_NONE   = 3'h0;
  localparam CL_IMM    = 3'h1;
  localparam CL_IND    = 3'h2;
  localparam CL_BIT    = 3'h3;
  localparam CL_DP     = 3'h4;

  reg  [2:0]        state;
  reg  [2:0]        next_state;
  reg  [DATA_W-1:0] next_acc;
  reg               load_acc;
  wire              par_new;
  wire [2:0]        op_class;
  wire              take_opc;
  wire              take_bit_addr;
  wire              take_dp_high;
  wire              take_dp_low;
  wire              finish_one;
  wire              finish_two;
  wire [DATA_W-1:0] ptr_value;

  ////////////////////////////////////////////////////////////////////////
  // unknown opcodes fall into CL_NONE and are dropped while idle
  function [2:0] f_op_class;
    input [DATA_W-1:0] opc;
    begin
      if (opc == `MVD_OP_MOV_A_IMM)
        f_op_class = CL_IMM;
      else if (opc[7:1] == `MVD_OP_MOV_A_IND)
        f_op_class = CL_IND;
      else if (opc == `MVD_OP_MOV_C_BIT)
        f_op_class = CL_BIT;
      else if (opc == `MVD_OP_MOV_DP_IMM)
        f_op_class = CL_DP;
      else
        f_op_class = CL_NONE;
    end
  endfunction

  // bank choice happens upstream, so only the low opcode bit picks the pointer
  function [DATA_W-1:0] f_pick_ptr;
    input              sel;
    input [DATA_W-1:0] reg0;
    input [DATA_W-1:0] reg1;
    begin
      f_pick_ptr = sel ? reg1 : reg0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign op_class      = f_op_class(byte_i);
  assign take_opc      = (state == ST_OPC) && byte_valid_i;
  assign take_bit_addr = (state == ST_BITA) && byte_valid_i;
  assign take_dp_high  = (state == ST_DPH) && byte_valid_i;
  assign take_dp_low   = (state == ST_DPL) && byte_valid_i;
  assign finish_one    = ((state == ST_IMM) && byte_valid_i) || (state == ST_IND) || (state == ST_BITV);
  assign finish_two    = take_dp_low;
  assign ptr_value     = f_pick_ptr(byte_i[0], work_reg0_i, work_reg1_i);

  mvd_parity #(
    .WIDTH (DATA_W)
  ) u_par (
    .data_i   (next_acc),
    .parity_o (par_new)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state and accumulator source
  always @* begin
    next_state = state;
    next_acc   = accumulator_o;
    load_acc   = 1'b0;
    case (state)
      ST_OPC: begin
        if (byte_valid_i) begin
          case (op_class)
            CL_IMM:  next_state = ST_IMM;
            CL_IND:  next_state = ST_IND;
            CL_BIT:  next_state = ST_BITA;
            CL_DP:   next_state = ST_DPH;
            default: next_state = ST_OPC;
          endcase
        end
      end
      ST_IMM: begin
        if (byte_valid_i) begin
          next_acc   = byte_i;
          load_acc   = 1'b1;
          next_state = ST_OPC;
        end
      end
      // read data must settle in the same cycle mem_addr_o holds the address; no wait states
      ST_IND: begin
        next_acc   = mem_data_i;
        load_acc   = 1'b1;
        next_state = ST_OPC;
      end
      ST_BITA: begin
        if (byte_valid_i)
          next_state = ST_BITV;
      end
      ST_BITV: begin
        next_state = ST_OPC;
      end
      ST_DPH: begin
        if (byte_valid_i)
          next_state = ST_DPL;
      end
      ST_DPL: begin
        if (byte_valid_i)
          next_state = ST_OPC;
      end
      default: begin
        next_state = ST_OPC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    if (!rst_b_i)
      state <= ST_OPC;
    else
      state <= next_state;
  end

  // busy follows the state, so it falls in the same cycle done rises
  always @(posedge ref_clk_i) begin
    if (!rst_b_i)
      busy_o <= 1'b0;
    else
      busy_o <= (next_state != ST_OPC);
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    if (!rst_b_i)
      accumulator_o <= `MVD_RST_ACC;
    else if (load_acc)
      accumulator_o <= next_acc;
  end

  // only carry and parity are written; the other status bits keep their value
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      program_status_word_o <= `MVD_RST_PSW;
    end else begin
      if (load_acc)
        program_status_word_o[`MVD_PSW_P] <= par_new;
      if (state == ST_BITV)
        program_status_word_o[`MVD_PSW_CY] <= bit_value_i;
    end
  end

  // high byte lands first, so the pointer is half updated for at least one cycle, until the low byte arrives
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      data_pointer_o <= `MVD_RST_DP;
    end else begin
      if (take_dp_high)
        data_pointer_o[2*DATA_W-1:DATA_W] <= byte_i;
      if (take_dp_low)
        data_pointer_o[DATA_W-1:0] <= byte_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer register itself is never written, only its value used
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      mem_addr_o <= {DATA_W{1'b0}};
      mem_rd_o   <= 1'b0;
    end else begin
      mem_rd_o <= 1'b0;
      if (take_opc && (op_class == CL_IND)) begin
        mem_addr_o <= ptr_value;
        mem_rd_o   <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      bit_addr_o <= {DATA_W{1'b0}};
      bit_rd_o   <= 1'b0;
    end else begin
      bit_rd_o <= 1'b0;
      if (take_bit_addr) begin
        bit_addr_o <= byte_i;
        bit_rd_o   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycles_o reports machine cycles of the last instruction, not clock edges
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      done_o   <= 1'b0;
      cycles_o <= 2'h0;
    end else begin
      done_o <= finish_one || finish_two;
      if (finish_one)
        cycles_o <= `MVD_CYC_ONE;
      else if (finish_two)
        cycles_o <= `MVD_CYC_TWO;
    end
  end
endmodule

// ==== verification/mvd_assertions.sv ====
// port checker for mvd_move_decode
// one clock, sync active-low reset
`timescale 1ns/1ps
module mvd_checker (
  input wire        ref_clk_i,
  input wire        rst_b_i,
  input wire        byte_valid_i,
  input wire [7:0]  byte_i,
  input wire [7:0]  work_reg0_i,
  input wire [7:0]  work_reg1_i,
  input wire [7:0]  mem_data_i,
  input wire        bit_value_i,
  input wire [7:0]  mem_addr_o,
  input wire        mem_rd_o,
  input wire [7:0]  bit_addr_o,
  input wire        bit_rd_o,
  input wire [7:0]  accumulator_o,
  input wire [7:0]  program_status_word_o,
  input wire [15:0] data_pointer_o,
  input wire        busy_o,
  input wire        done_o,
  input wire [1:0]  cycles_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire [7:0] a = accumulator_o, s = program_status_word_o, p = byte_i[0] ? work_reg1_i : work_reg0_i;
  wire       go = byte_valid_i && !busy_o;
  wire       ind = go && byte_i[7:1] == 7'h73;
  sequence s_op(logic [7:0] op); go && byte_i == op ##1 byte_valid_i; endsequence
  property p_imm; s_op(8'h74) |=> done_o && cycles_o == 2'h1 && a == $past(byte_i); endproperty
  a_imm: assert property (p_imm) else $error("imm");
  property p_par; done_o |-> s[0] == ^a; endproperty
  a_par: assert property (p_par) else $error("par");
  property p_ind; ind |=> mem_rd_o && mem_addr_o == $past(p); endproperty
  a_ind: assert property (p_ind) else $error("ind");
  property p_ld; ind |-> ##2 done_o && a == $past(mem_data_i); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_bit; s_op(8'ha2) |=> bit_rd_o && bit_addr_o == $past(byte_i) ##1 done_o && s[7] == $past(bit_value_i);
  endproperty
  a_bit: assert property (p_bit) else $error("bit");
  property p_dp; s_op(8'h90) ##1 byte_valid_i |=> done_o && cycles_o == 2'h2
    && data_pointer_o == {$past(byte_i, 2), $past(byte_i)}; endproperty
  a_dp: assert property (p_dp) else $error("dp");
  // three cycles spans the whole bit move and pointer load
  property p_keep; go && (byte_i == 8'ha2 || byte_i == 8'h90) |=> ($stable(a) && $stable(s[6:0]))[*3]; endproperty
  a_keep: assert property (p_keep) else $error("keep");
endmodule
bind mvd_move_decode mvd_checker u_mvd_checker (
  .ref_clk_i             (ref_clk_i),
  .rst_b_i               (rst_b_i),
  .byte_valid_i          (byte_valid_i),
  .byte_i                (byte_i),
  .work_reg0_i           (work_reg0_i),
  .work_reg1_i           (work_reg1_i),
  .mem_data_i            (mem_data_i),
  .bit_value_i           (bit_value_i),
  .mem_addr_o            (mem_addr_o),
  .mem_rd_o              (mem_rd_o),
  .bit_addr_o            (bit_addr_o),
  .bit_rd_o              (bit_rd_o),
  .accumulator_o         (accumulator_o),
  .program_status_word_o (program_status_word_o),
  .data_pointer_o        (data_pointer_o),
  .busy_o                (busy_o),
  .done_o                (done_o),
  .cycles_o              (cycles_o)
);

// ==== verification/mvd_mem_model.sv ====
// data memory and bit space behind the decoder
// reads combinational; unselected reads give scrambled data so stale values never match
`timescale 1ns/1ps
module mvd_mem_model (
  input  wire [7:0] addr_i,
  input  wire [7:0] bit_addr_i,
  input  wire       rd_i,
  input  wire       bit_rd_i,
  output wire [7:0] data_o,
  output wire       bit_o
);
  assign data_o = rd_i ? addr_i ^ 8'h5a : addr_i ^ 8'ha5;
  assign bit_o = bit_rd_i ? ^bit_addr_i : ~^bit_addr_i;
endmodule

// ==== verification/mvd_move_decode_tb_top.sv ====
// bench for mvd_move_decode; bytes driven on the falling edge
`timescale 1ns/1ps
module mvd_move_decode_tb_top;
  reg         ref_clk_i = 0, rst_b_i = 0, byte_valid_i = 0;
  reg  [7:0]  byte_i = 0, work_reg0_i = 8'h3c, work_reg1_i = 8'hc1, ea = 0, es = 0;
  reg  [15:0] ed = 0, n;
  wire [7:0]  mem_data_i, mem_addr_o, bit_addr_o, accumulator_o, program_status_word_o;
  wire        bit_value_i, mem_rd_o, bit_rd_o, busy_o, done_o;
  wire [15:0] data_pointer_o;
  wire [1:0]  cycles_o;
  integer     miscompares = 0, num_checks = 0, ticks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  mvd_move_decode u_mvd_move_decode (
    .ref_clk_i             (ref_clk_i),
    .rst_b_i               (rst_b_i),
    .byte_valid_i          (byte_valid_i),
    .byte_i                (byte_i),
    .work_reg0_i           (work_reg0_i),
    .work_reg1_i           (work_reg1_i),
    .mem_data_i            (mem_data_i),
    .bit_value_i           (bit_value_i),
    .mem_addr_o            (mem_addr_o),
    .mem_rd_o              (mem_rd_o),
    .bit_addr_o            (bit_addr_o),
    .bit_rd_o              (bit_rd_o),
    .accumulator_o         (accumulator_o),
    .program_status_word_o (program_status_word_o),
    .data_pointer_o        (data_pointer_o),
    .busy_o                (busy_o),
    .done_o                (done_o),
    .cycles_o              (cycles_o)
  );
  mvd_mem_model u_mvd_mem_model (.addr_i(mem_addr_o), .bit_addr_i(bit_addr_o), .rd_i(mem_rd_o), .bit_rd_i(bit_rd_o),
    .data_o(mem_data_i), .bit_o(bit_value_i));
  ////////////////////////////////////////////////////////////
  task chk(input [15:0] g, e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin miscompares = miscompares + 1; $display("mismatch %0t got %h want %h", $time, g, e); end
    end
  endtask
  task put(input [7:0] b);
    begin @(negedge ref_clk_i); byte_valid_i = 1; byte_i = b; end
  endtask
  // n counts falling edges after byte_valid_i drops until done
  task run(input [1:0] k, input [7:0] b0, b1, b2, input [15:0] en, ec);
    begin
      put(b0);
      if (k > 1) put(b1);
      else begin @(negedge ref_clk_i); byte_valid_i = 0; end
      chk(busy_o, 1'b1);
      if (k > 2) put(b2);
      if (k > 1) begin @(negedge ref_clk_i); byte_valid_i = 0; end
      n = 0;
      while (done_o !== 1'b1 && n < 4) begin @(negedge ref_clk_i); n = n + 1; end
      chk(n, en);
      chk(cycles_o, ec);
      chk(busy_o, 1'b0);
      chk(accumulator_o, ea);
      chk(program_status_word_o, es);
      chk(data_pointer_o, ed);
      $display("test done %0t", $time);
    end
  endtask
  task t_imm(input [7:0] d); begin ea = d; es[0] = ^d; run(2, 8'h74, d, 0, 0, 1); end endtask
  task t_ind(input r); begin ea = (r ? work_reg1_i : work_reg0_i) ^ 8'h5a; es[0] = ^ea;
    run(1, {7'h73, r}, 0, 0, 1, 1); end endtask
  task t_bit(input [7:0] b); begin es[7] = ^b; run(2, 8'ha2, b, 0, 1, 1); end endtask
  task t_dp(input [7:0] h, l); begin ed = {h, l}; run(3, 8'h90, h, l, 0, 2); end endtask
  ////////////////////////////////////////////////////////////
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // generous ceiling; the sequence needs about 40 cycles
  always @(posedge ref_clk_i) begin
    ticks = ticks + 1;
    if (ticks == 400) begin
      miscompares = miscompares + 1;
      $display("mismatch %0t run exceeded its cycle ceiling", $time);
      conclude;
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1;
    t_imm(8'h07);
    t_bit(8'h34);
    t_ind(0);
    t_ind(1);
    t_bit(8'h35);
    t_dp(8'h0a, 8'hf5);
    t_imm(8'hb6);
    conclude;
  end
endmodule
